// [rtl/pbt_pkg.sv]
package pbt_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] PAIR_A_LOW_COUNT_IDX    = 10'h106;
  localparam logic [9:0] PAIR_A_HIGH_HOLD_IDX    = 10'h108;
  localparam logic [9:0] PAIR_A_HIGH_COUNT_IDX   = 10'h10a;
  localparam logic [9:0] PAIR_A_LOW_PERIOD_IDX   = 10'h10c;
  localparam logic [9:0] PAIR_A_HIGH_PERIOD_IDX  = 10'h10e;
  localparam logic [9:0] PAIR_A_LOW_CONTROL_IDX  = 10'h110;
  localparam logic [9:0] PAIR_A_HIGH_CONTROL_IDX = 10'h112;
  localparam logic [9:0] PAIR_B_LOW_COUNT_IDX    = 10'h114;
  localparam logic [9:0] PAIR_B_HIGH_HOLD_IDX    = 10'h116;
  localparam logic [9:0] PAIR_B_HIGH_COUNT_IDX   = 10'h118;
  localparam logic [9:0] PAIR_B_LOW_PERIOD_IDX   = 10'h11a;
  localparam logic [9:0] PAIR_B_HIGH_PERIOD_IDX  = 10'h11c;
  localparam logic [9:0] PAIR_B_LOW_CONTROL_IDX  = 10'h11e;
  localparam logic [9:0] PAIR_B_HIGH_CONTROL_IDX = 10'h120;
  localparam logic [9:0] IRQ_STATUS_IDX          = 10'h122;
  localparam logic [9:0] IRQ_ENABLE_IDX          = 10'h124;

  // Per-pair views of the same indices, pair A in element 0
  localparam logic [1:0][9:0] LOW_COUNT_IDX   = {PAIR_B_LOW_COUNT_IDX, PAIR_A_LOW_COUNT_IDX};
  localparam logic [1:0][9:0] HIGH_HOLD_IDX   = {PAIR_B_HIGH_HOLD_IDX, PAIR_A_HIGH_HOLD_IDX};
  localparam logic [1:0][9:0] HIGH_COUNT_IDX  = {PAIR_B_HIGH_COUNT_IDX, PAIR_A_HIGH_COUNT_IDX};
  localparam logic [1:0][9:0] LOW_PERIOD_IDX  = {PAIR_B_LOW_PERIOD_IDX, PAIR_A_LOW_PERIOD_IDX};
  localparam logic [1:0][9:0] HIGH_PERIOD_IDX = {PAIR_B_HIGH_PERIOD_IDX, PAIR_A_HIGH_PERIOD_IDX};
  localparam logic [1:0][9:0] LOW_CONTROL_IDX = {PAIR_B_LOW_CONTROL_IDX, PAIR_A_LOW_CONTROL_IDX};
  localparam logic [1:0][9:0] HIGH_CONTROL_IDX =
    {PAIR_B_HIGH_CONTROL_IDX, PAIR_A_HIGH_CONTROL_IDX};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RUN_ENABLE_BIT    = 15;
  localparam int STOP_IN_IDLE_BIT  = 13;
  localparam int GATED_ACC_BIT     = 6;
  localparam int PRESCALE_MSB      = 5;
  localparam int PRESCALE_LSB      = 4;
  localparam int JOIN_MODE_BIT     = 3;
  localparam int CLOCK_SOURCE_BIT  = 1;
  localparam int PAIR_A_IRQ_BIT    = 7;
  localparam int PAIR_B_IRQ_BIT    = 8;

  // Writable bits of the control registers
  localparam logic [15:0] LOW_CONTROL_MASK  = 16'ha07a;
  localparam logic [15:0] HIGH_CONTROL_MASK = 16'ha070;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] PERIOD_RESET  = 16'hffff;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;   // Oscillator divided by four
  localparam logic [7:0]  PRESC_LAST_DIV1   = 8'h00;
  localparam logic [7:0]  PRESC_LAST_DIV8   = 8'h07;
  localparam logic [7:0]  PRESC_LAST_DIV64  = 8'h3f;
  localparam logic [7:0]  PRESC_LAST_DIV256 = 8'hff;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pbt_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pbt_apb_rsp_s;

  typedef struct packed {
    logic [1:0] gate_clock_input;  // One pin per pair
    logic       sleep;
    logic       idle;
  } pbt_pins_s;

  typedef struct packed {
    logic [3:0][15:0] count;
    logic [1:0][15:0] hold;
    logic [3:0][15:0] period;
    logic [3:0][15:0] ctrl;
    logic [3:0][7:0]  presc;
    logic [1:0]       div;
    logic [1:0]       pin_prev;
    logic [1:0]       flag;
    logic [1:0]       irq_en;
    logic [15:0]      snap;
    logic [31:0]      rdata;
    logic             ack;
    logic             err;
    logic             adc_trig;
  } pbt_state_s;

  localparam pbt_state_s STATE_RESET = '{
    count:    {4{COUNT_RESET}},
    hold:     {2{COUNT_RESET}},
    period:   {4{PERIOD_RESET}},
    ctrl:     {4{CONTROL_RESET}},
    presc:    '0,
    div:      '0,
    pin_prev: '0,
    flag:     '0,
    irq_en:   '0,
    snap:     '0,
    rdata:    '0,
    ack:      1'b0,
    err:      1'b0,
    adc_trig: 1'b0
  };

endpackage : pbt_pkg

// [rtl/pbt_timers.sv]
// Contract
// - Pair A full 32-bit period match pulses the converter trigger.
// - Prescale field bits 5:4 picks divide by 1, 8, 64 or 256.
// - Joined pair uses low timer clock and prescaler; high prescale ignored.
// - Count register writes while the timer runs, and device reset, clear the prescaler.
// - Run enable is bit 15; clearing either clears the prescaler.
// - Disabled low timer prescaler is halted and not reset.
// - Control writes never change any count.
// - No counting while the processor sleeps.
// - Joined pair raises events on period match and gate falling edge.
// - Pair A events set status bit 7; only software clears it.
// - Pair A request reaches processor only when enable bit 7 set.
// - Pair B never produces a converter trigger.
// - Pair B counts are not offered as a time base.
// - Pair B low timer holds low half, upper timer high half.
// - Joined pair B ignores upper control; low control sets up.
// - Joined pair B interrupts use the upper timer flag and enable.
// - Low control bit 3 joins the pair; upper control lacks it.
// - Each pair has a high-word holding register for joined use.
// - Clock source bit picks instruction clock or external clock.
// - Joined count increments to period, then wraps to zero.
// - Low count read copies high count into the holding register.
// - Low count write loads held value into the high count.
// - Gated mode counts while gate high, stops on fall, keeps count.
`timescale 1ns/10ps

module pbt_timers (
  input  logic                  core_clk,
  input  logic                  rst_n,
  input  pbt_pkg::pbt_apb_req_s apb_req,
  output pbt_pkg::pbt_apb_rsp_s apb_rsp,
  input  pbt_pkg::pbt_pins_s    pins,
  output logic                  adc_trigger,
  output logic [31:0]           pair_a_timebase,
  output logic [1:0]            irq_request
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Last prescaler count before a step is passed on
  function automatic logic [7:0] presc_last(input logic [1:0] sel);
    logic [7:0] v;
    // Default keeps the function total
    v = pbt_pkg::PRESC_LAST_DIV1;
    unique case (sel)
      2'b00: v = pbt_pkg::PRESC_LAST_DIV1;
      2'b01: v = pbt_pkg::PRESC_LAST_DIV8;
      2'b10: v = pbt_pkg::PRESC_LAST_DIV64;
      2'b11: v = pbt_pkg::PRESC_LAST_DIV256;
    endcase
    return v;
  endfunction : presc_last

  // Read decode: bit 32 flags a mapped register
  function automatic logic [32:0] read_reg(input pbt_pkg::pbt_state_s s,
                                           input logic [9:0]         idx);
    logic [32:0] v;
    v = '0;
    // Timer words, pair A then pair B
    for (int p = 0; p < 2; p++) begin
      if (idx == pbt_pkg::LOW_COUNT_IDX[p]) begin
        v = {1'b1, 16'h0000, s.count[2*p]};
      end
      if (idx == pbt_pkg::HIGH_HOLD_IDX[p]) begin
        v = {1'b1, 16'h0000, s.hold[p]};
      end
      if (idx == pbt_pkg::HIGH_COUNT_IDX[p]) begin
        v = {1'b1, 16'h0000, s.count[2*p+1]};
      end
      if (idx == pbt_pkg::LOW_PERIOD_IDX[p]) begin
        v = {1'b1, 16'h0000, s.period[2*p]};
      end
      if (idx == pbt_pkg::HIGH_PERIOD_IDX[p]) begin
        v = {1'b1, 16'h0000, s.period[2*p+1]};
      end
      if (idx == pbt_pkg::LOW_CONTROL_IDX[p]) begin
        v = {1'b1, 16'h0000, s.ctrl[2*p]};
      end
      if (idx == pbt_pkg::HIGH_CONTROL_IDX[p]) begin
        v = {1'b1, 16'h0000, s.ctrl[2*p+1]};
      end
    end
    // Flag and enable words share one bit layout
    if (idx == pbt_pkg::IRQ_STATUS_IDX) begin
      v = '0;
      v[32] = 1'b1;
      v[pbt_pkg::PAIR_A_IRQ_BIT] = s.flag[0];
      v[pbt_pkg::PAIR_B_IRQ_BIT] = s.flag[1];
    end
    if (idx == pbt_pkg::IRQ_ENABLE_IDX) begin
      v = '0;
      v[32] = 1'b1;
      v[pbt_pkg::PAIR_A_IRQ_BIT] = s.irq_en[0];
      v[pbt_pkg::PAIR_B_IRQ_BIT] = s.irq_en[1];
    end
    return v;
  endfunction : read_reg

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Whole state in one struct, filled by one comb block
  pbt_pkg::pbt_state_s r_reg;
  pbt_pkg::pbt_state_s r_next;

  // Bus phase decode
  logic        setup_phase;
  logic        commit;
  logic        wr;
  logic        aligned;
  logic [9:0]  idx;
  logic [32:0] rd;
  logic        tcy;

  // Access commits only once ready has been shown
  assign setup_phase = apb_req.psel & ~apb_req.penable;
  assign commit      = apb_req.psel & apb_req.penable & r_reg.ack;
  assign wr          = commit & apb_req.pwrite;
  assign aligned     = (apb_req.paddr[1:0] == 2'b00);
  assign idx         = apb_req.paddr[11:2];
  assign rd          = read_reg(r_reg, idx);

  // instruction clock
  // Oscillator divided by four; the divider stops in sleep with the clocks
  assign tcy = ~pins.sleep & (r_reg.div == pbt_pkg::INSTR_DIV_LAST);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] c;
    logic [15:0] lc;
    logic        join_mode;
    logic        run;
    logic        src;
    logic [1:0]  step;
    logic [1:0]  raw;
    logic        ev;
    logic        presc_clr;
    logic        clr;
    int          t;
    // Defaults first, so no latch can form
    c         = '0;
    lc        = '0;
    join_mode = 1'b0;
    run       = 1'b0;
    src       = 1'b0;
    step      = '0;
    raw       = '0;
    ev        = 1'b0;
    presc_clr = 1'b0;
    clr       = 1'b0;
    t         = 0;
    // Hold all state; pulses and ack fall by default
    r_next          = r_reg;
    r_next.ack      = 1'b0;
    r_next.adc_trig = 1'b0;
    r_next.pin_prev = pins.gate_clock_input;

    if (!pins.sleep) begin
      r_next.div = r_reg.div + 2'd1;
    end

    // Setup cycle samples read data one cycle ahead of pready
    if (setup_phase) begin
      r_next.ack   = 1'b1;
      // Misaligned reads return zero
      r_next.rdata = aligned ? rd[31:0] : 32'h0000_0000;
      r_next.err   = ~(rd[32] & aligned);
      for (int p = 0; p < 2; p++) begin
        if (idx == pbt_pkg::LOW_COUNT_IDX[p]) begin
          r_next.snap = r_reg.count[2*p+1];
        end
      end
    end

    // One body serves both pairs; p picks the pair
    for (int p = 0; p < 2; p++) begin
      ev        = 1'b0;
      presc_clr = 1'b0;
      step      = '0;
      raw       = '0;
      lc        = r_reg.ctrl[2*p];
      join_mode = lc[pbt_pkg::JOIN_MODE_BIT];

      // Tick and prescaler for each half of the pair
      for (int k = 0; k < 2; k++) begin
        t = 2*p + k;
        c = join_mode ? lc : r_reg.ctrl[t];
        run = c[pbt_pkg::RUN_ENABLE_BIT] & ~pins.sleep &
              ~(pins.idle & c[pbt_pkg::STOP_IN_IDLE_BIT]);
        if (k == 0 && c[pbt_pkg::CLOCK_SOURCE_BIT]) begin
          src = pins.gate_clock_input[p] & ~r_reg.pin_prev[p];
        end else begin
          src = tcy & (~c[pbt_pkg::GATED_ACC_BIT] | pins.gate_clock_input[p]);
        end
        raw[k] = run & src & ~(join_mode && k == 1);
        if (raw[k]) begin
          if (r_reg.presc[t] == presc_last(c[pbt_pkg::PRESCALE_MSB:pbt_pkg::PRESCALE_LSB])) begin
            r_next.presc[t] = 8'h00;
            step[k]         = 1'b1;
          end else begin
            r_next.presc[t] = r_reg.presc[t] + 8'd1;
          end
        end
      end

      if (join_mode) begin
        if (step[0]) begin
          if ({r_reg.count[2*p+1], r_reg.count[2*p]} ==
              {r_reg.period[2*p+1], r_reg.period[2*p]}) begin
            r_next.count[2*p]   = 16'h0000;
            r_next.count[2*p+1] = 16'h0000;
            ev = 1'b1;
            if (p == 0) begin
              r_next.adc_trig = 1'b1;
            end
          end else begin
            // One add carries the low word into the high
            {r_next.count[2*p+1], r_next.count[2*p]} =
              {r_reg.count[2*p+1], r_reg.count[2*p]} + 32'd1;
          end
        end
      end else begin
        // Independent halves; only the high half owns an interrupt flag
        for (int k = 0; k < 2; k++) begin
          t = 2*p + k;
          if (step[k]) begin
            if (r_reg.count[t] == r_reg.period[t]) begin
              r_next.count[t] = 16'h0000;
              // Low half match raises no event when split
              ev = ev | (k == 1);
            end else begin
              r_next.count[t] = r_reg.count[t] + 16'd1;
            end
          end
        end
      end

      // Seen even asleep, as the pin is sampled each cycle
      // gate falling edge
      c = join_mode ? lc : r_reg.ctrl[2*p+1];
      if (c[pbt_pkg::GATED_ACC_BIT] && c[pbt_pkg::RUN_ENABLE_BIT] &&
          !(join_mode && lc[pbt_pkg::CLOCK_SOURCE_BIT]) &&
          r_reg.pin_prev[p] && !pins.gate_clock_input[p]) begin
        ev = 1'b1;
      end

      // Register writes take effect at the completing access edge
      if (wr && aligned) begin
        if (idx == pbt_pkg::LOW_CONTROL_IDX[p]) begin
          r_next.ctrl[2*p] = apb_req.pwdata[15:0] & pbt_pkg::LOW_CONTROL_MASK;
          if (lc[pbt_pkg::RUN_ENABLE_BIT] && !apb_req.pwdata[pbt_pkg::RUN_ENABLE_BIT]) begin
            presc_clr = 1'b1;
          end
        end
        if (idx == pbt_pkg::HIGH_CONTROL_IDX[p]) begin
          r_next.ctrl[2*p+1] = apb_req.pwdata[15:0] & pbt_pkg::HIGH_CONTROL_MASK;
          if (r_reg.ctrl[2*p+1][pbt_pkg::RUN_ENABLE_BIT] &&
              !apb_req.pwdata[pbt_pkg::RUN_ENABLE_BIT]) begin
            presc_clr = 1'b1;
          end
        end
        if (idx == pbt_pkg::LOW_COUNT_IDX[p]) begin
          r_next.count[2*p] = apb_req.pwdata[15:0];
          if (join_mode) begin
            r_next.count[2*p+1] = r_reg.hold[p];
          end
          presc_clr = presc_clr | lc[pbt_pkg::RUN_ENABLE_BIT];
        end
        if (idx == pbt_pkg::HIGH_COUNT_IDX[p]) begin
          r_next.count[2*p+1] = apb_req.pwdata[15:0];
          // Either run bit, as a split high half runs alone
          presc_clr = presc_clr | lc[pbt_pkg::RUN_ENABLE_BIT] |
                      r_reg.ctrl[2*p+1][pbt_pkg::RUN_ENABLE_BIT];
        end
        if (idx == pbt_pkg::HIGH_HOLD_IDX[p]) begin
          r_next.hold[p] = apb_req.pwdata[15:0];
        end
        // New periods apply from the next step
        if (idx == pbt_pkg::LOW_PERIOD_IDX[p]) begin
          r_next.period[2*p] = apb_req.pwdata[15:0];
        end
        if (idx == pbt_pkg::HIGH_PERIOD_IDX[p]) begin
          r_next.period[2*p+1] = apb_req.pwdata[15:0];
        end
      end

      // coherent read latch
      // Snapshot was taken at setup, so both halves come from one instant
      if (commit && !apb_req.pwrite && aligned && join_mode &&
          idx == pbt_pkg::LOW_COUNT_IDX[p]) begin
        r_next.hold[p] = r_reg.snap;
      end

      // Clear both halves; joined mode uses only the low one
      if (presc_clr) begin
        r_next.presc[2*p]   = 8'h00;
        r_next.presc[2*p+1] = 8'h00;
      end

      // upper timer flag
      // Event in the clearing cycle wins over the clear
      clr = wr && aligned && idx == pbt_pkg::IRQ_STATUS_IDX &&
            !apb_req.pwdata[(p == 0) ? pbt_pkg::PAIR_A_IRQ_BIT : pbt_pkg::PAIR_B_IRQ_BIT];
      r_next.flag[p] = ev | (r_reg.flag[p] & ~clr);

      // Enable bits simply follow the written word
      if (wr && aligned && idx == pbt_pkg::IRQ_ENABLE_IDX) begin
        r_next.irq_en[p] =
          apb_req.pwdata[(p == 0) ? pbt_pkg::PAIR_A_IRQ_BIT : pbt_pkg::PAIR_B_IRQ_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  always_ff @(posedge core_clk) begin
    // One struct, so reset is one assignment
    if (!rst_n) begin
      r_reg <= pbt_pkg::STATE_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Bus answer, one wait-free access cycle after setup
  assign apb_rsp.pready  = r_reg.ack;
  assign apb_rsp.pslverr = r_reg.ack & r_reg.err;
  assign apb_rsp.prdata  = r_reg.rdata;

  // Registered, one cycle wide
  assign adc_trigger = r_reg.adc_trig;

  assign pair_a_timebase = {r_reg.count[1], r_reg.count[0]};

  assign irq_request = r_reg.flag & r_reg.irq_en;

endmodule : pbt_timers

// [verification/pbt_timers_asserts.sv]
`timescale 1ns/10ps

module pbt_chk (
  input logic                  core_clk,
  input logic                  rst_n,
  input pbt_pkg::pbt_apb_req_s apb_req,
  input pbt_pkg::pbt_apb_rsp_s apb_rsp,
  input pbt_pkg::pbt_pins_s    pins,
  input logic                  adc_trigger,
  input logic [31:0]           pair_a_timebase,
  input logic [1:0]            irq_request
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  logic [9:0] idx;
  logic       irq_wr;
  assign idx = apb_req.paddr[11:2];
  // Software is the only party allowed to drop a flag or an enable
  assign irq_wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite &&
                  (idx == pbt_pkg::IRQ_STATUS_IDX || idx == pbt_pkg::IRQ_ENABLE_IDX);

  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_ctrl_read;
    apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite &&
    (idx == pbt_pkg::PAIR_A_LOW_CONTROL_IDX || idx == pbt_pkg::PAIR_B_LOW_CONTROL_IDX);
  endsequence

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  a_ready_next: assert property (s_setup |=> apb_rsp.pready)
    else $error("no ready after setup");
  a_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  a_idle_quiet: assert property (!apb_req.psel |=> !apb_rsp.pready)
    else $error("ready without select");
  a_misalign_err: assert property ((s_setup ##0 apb_req.paddr[1:0] != 2'b00) |=> apb_rsp.pslverr)
    else $error("misaligned access not refused");
  a_rdata_upper: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_ctrl_unused: assert property (
    s_ctrl_read |-> (apb_rsp.prdata[15:0] & 16'h5f85) == 16'h0000)
    else $error("unused control bits read back");

  // ----------------------------------------------------------------
  // Timer outputs
  // ----------------------------------------------------------------
  a_trig_pulse: assert property (adc_trigger |=> !adc_trigger)
    else $error("trigger longer than one cycle");
  a_sleep_hold: assert property (
    (pins.sleep && !apb_req.psel)[*3] |-> $stable(pair_a_timebase))
    else $error("count moved during sleep");
  a_flag_sticky: assert property (
    $fell(irq_request[0]) |-> $past(irq_wr, 1) || $past(irq_wr, 2))
    else $error("pair a request dropped by hardware");
  a_flag_b_sticky: assert property (
    $fell(irq_request[1]) |-> $past(irq_wr, 1) || $past(irq_wr, 2))
    else $error("pair b request dropped by hardware");
endmodule : pbt_chk

bind pbt_timers pbt_chk chk_u (
  .core_clk        (core_clk),
  .rst_n           (rst_n),
  .apb_req         (apb_req),
  .apb_rsp         (apb_rsp),
  .pins            (pins),
  .adc_trigger     (adc_trigger),
  .pair_a_timebase (pair_a_timebase),
  .irq_request     (irq_request)
);

// [verification/testbench.sv]
`timescale 1ns/10ps

module testbench;
  logic                  core_clk = 1'b0;
  logic                  rst_n = 1'b0;
  pbt_pkg::pbt_apb_req_s req = '0;
  pbt_pkg::pbt_apb_rsp_s rsp;
  pbt_pkg::pbt_pins_s    pins = '0;
  logic                  trig;
  logic [31:0]           tbase;
  logic [1:0]            irq;
  logic [31:0]           rdv;
  logic                  errv;
  logic [1:0]            lsb = 2'b00;
  int                    error_cnt = 0;
  int                    checks = 0;

  always #5 core_clk = ~core_clk;

  pbt_timers dut_u (.core_clk(core_clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .pins(pins), .adc_trigger(trig), .pair_a_timebase(tbase), .irq_request(irq));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One transfer; the wait is bounded and the latency is checked to be one edge
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, lsb}, pwdata: wd};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rdv = rsp.prdata;
    errv = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    chk(n, 1);
  endtask : apb

  // Edges until the next trigger, sampled as the edge sees it
  task automatic wait_trig(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (trig !== 1'b1 && n < 2000);
  endtask : wait_trig

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int p = 0; p < 2; p++) begin
      apb(0, pbt_pkg::LOW_PERIOD_IDX[p], 0);
      chk(rdv, 32'h0000_ffff);
      apb(0, pbt_pkg::HIGH_PERIOD_IDX[p], 0);
      chk(rdv, 32'h0000_ffff);
      apb(0, pbt_pkg::HIGH_CONTROL_IDX[p], 0);
      chk(rdv, 32'h0000_0000);
    end
    apb(0, 10'h3ff, 0);
    chk(errv, 1'b1);
    lsb = 2'b10;
    apb(0, pbt_pkg::LOW_PERIOD_IDX[0], 0);
    lsb = 2'b00;
    chk(errv, 1'b1);
    $display("reset values done");
  endtask : t_reset

  task automatic t_mask;
    for (int p = 0; p < 2; p++) begin
      apb(1, pbt_pkg::LOW_CONTROL_IDX[p], 32'h0000_ffff);
      apb(0, pbt_pkg::LOW_CONTROL_IDX[p], 0);
      chk(rdv, 32'h0000_a07a);
      apb(1, pbt_pkg::HIGH_CONTROL_IDX[p], 32'h0000_ffff);
      apb(0, pbt_pkg::HIGH_CONTROL_IDX[p], 0);
      chk(rdv, 32'h0000_a070);
      apb(1, pbt_pkg::LOW_CONTROL_IDX[p], 0);
      apb(1, pbt_pkg::HIGH_CONTROL_IDX[p], 0);
    end
    $display("control masks done");
  endtask : t_mask

  // Asleep, so the counts only change through the bus
  task automatic t_coherent;
    for (int p = 0; p < 2; p++) begin
      apb(1, pbt_pkg::LOW_CONTROL_IDX[p], 32'h0000_8008);
      apb(1, pbt_pkg::HIGH_HOLD_IDX[p], 32'h0000_1234);
      apb(1, pbt_pkg::LOW_COUNT_IDX[p], 32'h0000_5678);
      apb(1, pbt_pkg::LOW_CONTROL_IDX[p], 32'h0000_8018);
      repeat (6) @(posedge core_clk);
      apb(0, pbt_pkg::HIGH_COUNT_IDX[p], 0);
      chk(rdv, 32'h0000_1234);
      apb(1, pbt_pkg::HIGH_COUNT_IDX[p], 32'h0000_9abc);
      apb(0, pbt_pkg::LOW_COUNT_IDX[p], 0);
      chk(rdv, 32'h0000_5678);
      apb(0, pbt_pkg::HIGH_HOLD_IDX[p], 0);
      chk(rdv, 32'h0000_9abc);
      apb(1, pbt_pkg::LOW_CONTROL_IDX[p], 0);
    end
    chk(tbase, 32'h9abc_5678);
    $display("coherent access done");
  endtask : t_coherent

  task automatic t_wrap;
    int n;
    apb(1, pbt_pkg::LOW_PERIOD_IDX[0], 2);
    apb(1, pbt_pkg::HIGH_PERIOD_IDX[0], 0);
    apb(1, pbt_pkg::HIGH_CONTROL_IDX[0], 32'h0000_0030);
    apb(1, pbt_pkg::LOW_COUNT_IDX[0], 0);
    apb(1, pbt_pkg::HIGH_COUNT_IDX[0], 0);
    apb(1, pbt_pkg::IRQ_STATUS_IDX, 0);
    apb(1, pbt_pkg::LOW_CONTROL_IDX[0], 32'h0000_8008);
    wait_trig(n);
    wait_trig(n);
    chk(n, 12);
    chk(irq, 2'b00);
    apb(0, pbt_pkg::IRQ_STATUS_IDX, 0);
    chk(rdv & 32'h0000_0080, 32'h0000_0080);
    apb(1, pbt_pkg::IRQ_ENABLE_IDX, 32'h0000_0080);
    apb(1, pbt_pkg::LOW_CONTROL_IDX[0], 0);
    chk(irq, 2'b01);
    apb(1, pbt_pkg::IRQ_STATUS_IDX, 0);
    @(negedge core_clk);
    chk(irq, 2'b00);
    $display("period wrap done");
  endtask : t_wrap

  // Period zero matches on every step, so trigger spacing is the step
  task automatic t_presc;
    int n;
    int exp [4] = '{4, 32, 256, 1024};
    apb(1, pbt_pkg::LOW_PERIOD_IDX[0], 0);
    apb(1, pbt_pkg::LOW_COUNT_IDX[0], 0);
    for (int ps = 0; ps < 4; ps++) begin
      apb(1, pbt_pkg::LOW_CONTROL_IDX[0], 32'h0000_8008 | (ps << 4));
      wait_trig(n);
      wait_trig(n);
      chk(n, exp[ps]);
      apb(1, pbt_pkg::LOW_CONTROL_IDX[0], 0);
    end
    $display("prescaler done");
  endtask : t_presc

  task automatic t_pair_b;
    int k;
    k = 0;
    apb(1, pbt_pkg::LOW_PERIOD_IDX[1], 0);
    apb(1, pbt_pkg::HIGH_PERIOD_IDX[1], 0);
    apb(1, pbt_pkg::HIGH_COUNT_IDX[1], 0);
    apb(1, pbt_pkg::LOW_COUNT_IDX[1], 0);
    apb(1, pbt_pkg::LOW_CONTROL_IDX[1], 32'h0000_8008);
    repeat (60) begin
      @(posedge core_clk);
      k += (trig === 1'b1);
    end
    chk(k, 0);
    apb(1, pbt_pkg::IRQ_ENABLE_IDX, 32'h0000_0100);
    apb(1, pbt_pkg::LOW_CONTROL_IDX[1], 0);
    chk(irq, 2'b10);
    apb(1, pbt_pkg::IRQ_STATUS_IDX, 0);
    @(negedge core_clk);
    chk(irq, 2'b00);
    $display("pair b done");
  endtask : t_pair_b

  task automatic t_gate;
    apb(1, pbt_pkg::LOW_PERIOD_IDX[0], 32'h0000_ffff);
    apb(1, pbt_pkg::HIGH_PERIOD_IDX[0], 32'h0000_ffff);
    apb(1, pbt_pkg::LOW_COUNT_IDX[0], 0);
    apb(1, pbt_pkg::LOW_CONTROL_IDX[0], 32'h0000_8048);
    pins.gate_clock_input[0] <= 1'b1;
    repeat (40) @(posedge core_clk);
    pins.gate_clock_input[0] <= 1'b0;
    apb(0, pbt_pkg::IRQ_STATUS_IDX, 0);
    chk(rdv & 32'h0000_0080, 32'h0000_0080);
    apb(0, pbt_pkg::LOW_COUNT_IDX[0], 0);
    chk(rdv >= 9 && rdv <= 11, 1);
    repeat (40) @(posedge core_clk);
    chk(tbase, {16'h0000, rdv[15:0]});
    apb(1, pbt_pkg::LOW_CONTROL_IDX[0], 32'h0000_800a);
    apb(1, pbt_pkg::LOW_COUNT_IDX[0], 0);
    repeat (5) begin
      pins.gate_clock_input[0] <= 1'b1;
      repeat (3) @(posedge core_clk);
      pins.gate_clock_input[0] <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    apb(0, pbt_pkg::LOW_COUNT_IDX[0], 0);
    chk(rdv, 5);
    // Stop in idle; the control write keeps the count
    apb(1, pbt_pkg::LOW_CONTROL_IDX[0], 32'h0000_a00a);
    pins.idle <= 1'b1;
    repeat (2) begin
      pins.gate_clock_input[0] <= 1'b1;
      repeat (3) @(posedge core_clk);
      pins.gate_clock_input[0] <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    apb(0, pbt_pkg::LOW_COUNT_IDX[0], 0);
    pins.idle <= 1'b0;
    chk(rdv, 5);
    $display("gate and external clock done");
  endtask : t_gate

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset;
    pins.sleep <= 1'b1;
    t_mask;
    t_coherent;
    pins.sleep <= 1'b0;
    t_wrap;
    t_presc;
    t_pair_b;
    t_gate;
    conclude;
  end

  // Whole run is a few thousand cycles; this is far beyond it
  initial begin
    #300000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude;
  end
endmodule : testbench
